// file: rtl/shba_defines.svh
// Constants for the sponge hash byte accelerator: addresses, commands, timing.
// Assumes inclusion by the package and the core module only.
`ifndef SHBA_DEFINES_SVH
`define SHBA_DEFINES_SVH

`define SHBA_STATE_W      88
`define SHBA_RATE_W       8
`define SHBA_ROUNDS       45
`define SHBA_PERM_CYCLES  23
`define SHBA_LFSR_INIT    6'h05
`define SHBA_PAD_BYTE     8'h81
`define SHBA_ADDR_CMD     3'h0
`define SHBA_ADDR_ABSORB  3'h1
`define SHBA_ADDR_DIGEST  3'h2
`define SHBA_CMD_RESET    8'h00
`define SHBA_CMD_SQUEEZE  8'h01
`define SHBA_CMD_HASH     8'h02

`endif

// file: rtl/shba_pkg.sv
// Types for the sponge hash byte accelerator.
// Assumes shba_defines.svh is on the include path.
`default_nettype none
`include "shba_defines.svh"

package shba_pkg;

    typedef enum logic [1:0] {
        SHBA_IDLE    = 2'b00,
        SHBA_LOAD    = 2'b01,
        SHBA_PERMUTE = 2'b10,
        SHBA_CAPTURE = 2'b11
    } shba_fsm_type;

    typedef struct packed {
        logic       wr_strobe;
        logic       rd_strobe;
        logic [2:0] addr;
    } shba_ctrl_in_type;

    typedef struct packed {
        logic busy;
        logic out_valid;
    } shba_status_type;

endpackage

`default_nettype wire

// file: rtl/shba_core.sv
// Sponge hash engine with a byte-wide strobed register port.
// Assumes strobes and address come from pins of an asynchronous host.
`default_nettype none
`include "shba_defines.svh"

// Behaviour
// R1: 88-bit state, 8-bit rate, 80-bit capacity
// R2: 45 rounds: counter, substitution, bit permutation
// R3: 22 parallel 4-bit substitution lookups
// R4: Bit i moves to (i*22) mod 87
// R5: Top bit 87 stays in place
// R6: Counter into bits 5:0, reversed into 87:82
// R7: LFSR counter runs 05, 0A, 14, 29, 13
// R8: Two rounds per cycle, one in the last; 23 cycles per call
// R9: Absorb takes exactly 25 cycles
// R10: Address 1 write XORs rate, permutes
// R11: Command 0 clears state and digest-valid
// R12: Command 1 copies state to output register
// R13: Command 2 absorbs 0x81 then auto-squeezes
// R14: Host pads with 0x81 without command 2
// R15: Writes act on write strobe rising edge
// R16: Read strobe at address 2 advances digest
// R17: Output shows digest byte, LSB first
// R18: Busy high while permutation runs
// R19: Digest-valid rises on squeeze, held until reset
// R20: Host waits for busy low before writing
// R21: Writes during permutation are ignored
// R22: Strobes synchronised, rising edges act once
module shba_core
    import shba_pkg::*;
(
    input  wire logic                       ref_clk,
    input  wire logic                       sys_rst,
    input  wire logic [7:0]                 byte_input_bus,
    input  wire shba_pkg::shba_ctrl_in_type ctrl_in,
    output logic [7:0]                      byte_output_bus,
    output shba_pkg::shba_status_type       status
);
    import shba_pkg::*;

    localparam int STATE_W = `SHBA_STATE_W;

    // ------------------------------------------------------------
    // Round functions
    // ------------------------------------------------------------
    function automatic logic [3:0] sbox(input logic [3:0] x);
        logic [3:0] y;
        y = 4'h0;
        case (x)
            4'h0: y = 4'hE;
            4'h1: y = 4'hD;
            4'h2: y = 4'hB;
            4'h3: y = 4'h0;
            4'h4: y = 4'h2;
            4'h5: y = 4'h1;
            4'h6: y = 4'h4;
            4'h7: y = 4'hF;
            4'h8: y = 4'h7;
            4'h9: y = 4'hA;
            4'hA: y = 4'h8;
            4'hB: y = 4'h5;
            4'hC: y = 4'h9;
            4'hD: y = 4'hC;
            4'hE: y = 4'h3;
            4'hF: y = 4'h6;
            default: y = 4'h0;
        endcase
        return y;
    endfunction

    function automatic logic [5:0] lfsr_next(input logic [5:0] c);
        return {c[4:0], c[5] ^ c[4]}; // R7
    endfunction

    function automatic logic [5:0] rev6(input logic [5:0] c);
        return {c[0], c[1], c[2], c[3], c[4], c[5]};
    endfunction

    function automatic logic [STATE_W-1:0] round_fn(
        input logic [STATE_W-1:0] s_in,
        input logic [5:0]         cnt
    );
        logic [STATE_W-1:0] s;
        logic [STATE_W-1:0] t;
        s = s_in;
        t = '0;
        s[5:0]   = s[5:0] ^ cnt;           // R6
        s[87:82] = s[87:82] ^ rev6(cnt);   // R6
        for (int n = 0; n < 22; n++) begin
            s[4*n +: 4] = sbox(s[4*n +: 4]); // R3
        end
        for (int i = 0; i < 87; i++) begin
            t[(i * 22) % 87] = s[i];       // R4
        end
        t[87] = s[87];                     // R5
        return t;
    endfunction

    // ------------------------------------------------------------
    // Strobe synchronisers and edge detection
    // ------------------------------------------------------------
    logic [4:0] sync1_q, sync1_d;
    logic [4:0] sync2_q, sync2_d;
    logic       wr_prev_q, wr_prev_d;
    logic       rd_prev_q, rd_prev_d;
    logic [7:0] din_sync1_q, din_sync2_q;
    logic       wr_edge, rd_edge;
    logic [2:0] addr_s;

    always_comb begin
        sync1_d   = {ctrl_in.wr_strobe, ctrl_in.rd_strobe, ctrl_in.addr};
        sync2_d   = sync1_q;
        wr_prev_d = sync2_q[4];
        rd_prev_d = sync2_q[3];
    end

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            sync1_q     <= 5'h00;
            sync2_q     <= 5'h00;
            wr_prev_q   <= 1'b0;
            rd_prev_q   <= 1'b0;
            din_sync1_q <= 8'h00;
            din_sync2_q <= 8'h00;
        end else begin
            sync1_q     <= sync1_d;
            sync2_q     <= sync2_d;
            wr_prev_q   <= wr_prev_d;
            rd_prev_q   <= rd_prev_d;
            din_sync1_q <= byte_input_bus;
            din_sync2_q <= din_sync1_q;
        end
    end

    assign wr_edge = sync2_q[4] & ~wr_prev_q; // R15 R22
    assign rd_edge = sync2_q[3] & ~rd_prev_q; // R22
    assign addr_s  = sync2_q[2:0];

    // ------------------------------------------------------------
    // Sponge control
    // ------------------------------------------------------------
    shba_fsm_type        fsm_q, fsm_d;
    logic [STATE_W-1:0]  state_q, state_d;
    logic [STATE_W-1:0]  out_q, out_d;
    logic [5:0]          cnt_q, cnt_d;
    logic [4:0]          cyc_q, cyc_d;
    logic [7:0]          load_q, load_d;
    logic                auto_sq_q, auto_sq_d;
    logic                valid_q, valid_d;
    logic [STATE_W-1:0]  r1;

    always_comb begin
        fsm_d     = fsm_q;
        state_d   = state_q;
        out_d     = out_q;
        cnt_d     = cnt_q;
        cyc_d     = cyc_q;
        load_d    = load_q;
        auto_sq_d = auto_sq_q;
        valid_d   = valid_q;
        r1        = round_fn(state_q, cnt_q);
        case (fsm_q)
            SHBA_IDLE: begin
                // Writes only decoded here; others are dropped while busy
                if (wr_edge) begin // R21
                    if (addr_s == `SHBA_ADDR_ABSORB) begin
                        load_d    = din_sync2_q;
                        auto_sq_d = 1'b0;
                        fsm_d     = SHBA_LOAD; // R10
                    end else if (addr_s == `SHBA_ADDR_CMD) begin
                        case (din_sync2_q)
                            `SHBA_CMD_RESET: begin
                                state_d = '0;   // R11
                                valid_d = 1'b0; // R11 R19
                            end
                            `SHBA_CMD_SQUEEZE: begin
                                out_d   = state_q; // R12
                                valid_d = 1'b1;    // R19
                            end
                            `SHBA_CMD_HASH: begin
                                load_d    = `SHBA_PAD_BYTE; // R13
                                auto_sq_d = 1'b1;
                                fsm_d     = SHBA_LOAD;
                            end
                            default: begin
                                fsm_d = SHBA_IDLE;
                            end
                        endcase
                    end
                end
                if (rd_edge && addr_s == `SHBA_ADDR_DIGEST) begin
                    out_d = {8'h00, out_q[STATE_W-1:8]}; // R16 R17
                end
            end
            SHBA_LOAD: begin
                state_d[`SHBA_RATE_W-1:0] = state_q[`SHBA_RATE_W-1:0] ^ load_q; // R1 R10
                cnt_d = `SHBA_LFSR_INIT;
                cyc_d = 5'd0;
                fsm_d = SHBA_PERMUTE; // R9
            end
            SHBA_PERMUTE: begin
                if (cyc_q == 5'(`SHBA_PERM_CYCLES - 1)) begin
                    state_d = r1; // R2 R8
                    fsm_d   = SHBA_CAPTURE;
                end else begin
                    state_d = round_fn(r1, lfsr_next(cnt_q)); // R8
                    cnt_d   = lfsr_next(lfsr_next(cnt_q));
                    cyc_d   = cyc_q + 5'd1;
                end
            end
            SHBA_CAPTURE: begin
                if (auto_sq_q) begin
                    out_d   = state_q; // R13
                    valid_d = 1'b1;    // R19
                end
                auto_sq_d = 1'b0;
                fsm_d     = SHBA_IDLE; // R9
            end
            default: begin
                fsm_d = SHBA_IDLE;
            end
        endcase
    end

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            fsm_q     <= SHBA_IDLE;
            state_q   <= '0;
            out_q     <= '0;
            cnt_q     <= `SHBA_LFSR_INIT;
            cyc_q     <= 5'd0;
            load_q    <= 8'h00;
            auto_sq_q <= 1'b0;
            valid_q   <= 1'b0;
        end else begin
            fsm_q     <= fsm_d;
            state_q   <= state_d;
            out_q     <= out_d;
            cnt_q     <= cnt_d;
            cyc_q     <= cyc_d;
            load_q    <= load_d;
            auto_sq_q <= auto_sq_d;
            valid_q   <= valid_d;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign byte_output_bus  = out_q[7:0];               // R17
    assign status.busy      = (fsm_q != SHBA_IDLE);     // R18
    assign status.out_valid = valid_q;                  // R19

endmodule

`default_nettype wire

// file: dv/shba_core_asserts.sv
// Port checker for the sponge hash core.
// Assumes one clock and a synchronous active-high reset.
`default_nettype none
module shba_core_asserts
    import shba_pkg::*;
(
    input wire logic                       ref_clk,
    input wire logic                       sys_rst,
    input wire logic [7:0]                 byte_input_bus,
    input wire shba_pkg::shba_ctrl_in_type ctrl_in,
    input wire logic [7:0]                 byte_output_bus,
    input wire shba_pkg::shba_status_type  status
);
    timeunit 1ns;
    timeprecision 100ps;
    logic       wr_q, wr_d, req;
    logic [7:0] run_q, run_d, age_q, age_d, dat_q, dat_d;
    logic [2:0] adr_q, adr_d;
    // Pin-level write edge seen while idle
    assign req = ctrl_in.wr_strobe && !wr_q && !status.busy;
    always_comb begin
        wr_d = ctrl_in.wr_strobe;
        run_d = status.busy ? run_q + 8'h01 : 8'h00;
        age_d = (age_q == 8'hFF) ? age_q : age_q + 8'h01;
        adr_d = req ? ctrl_in.addr : adr_q;
        dat_d = req ? byte_input_bus : dat_q;
        if (req) begin
            age_d = 8'h00;
        end
    end
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            wr_q <= 1'b0;
            run_q <= 8'h00;
            age_q <= 8'hFF;
            adr_q <= 3'h7;
            dat_q <= 8'hFF;
        end else begin
            wr_q <= wr_d;
            run_q <= run_d;
            age_q <= age_d;
            adr_q <= adr_d;
            dat_q <= dat_d;
        end
    end
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (sys_rst);
    sequence absorb_req_s;
        req && ctrl_in.addr == 3'h1;
    endsequence
    sequence run_start_s;
        ##[1:8] $rose(status.busy);
    endsequence
    busy_length_a: assert property ($fell(status.busy) |-> run_q == 8'h19)
        else $error("busy run length wrong");
    absorb_start_a: assert property (absorb_req_s |-> run_start_s)
        else $error("absorb did not start");
    busy_cause_a: assert property ($rose(status.busy) |-> age_q <= 8'h08)
        else $error("run without fresh idle write");
    busy_kind_a: assert property ($rose(status.busy) |-> adr_q == 3'h1 ||
        (adr_q == 3'h0 && dat_q == 8'h02)) else $error("run from wrong request");
    valid_clear_a: assert property ($fell(status.out_valid) |-> adr_q == 3'h0 &&
        dat_q == 8'h00 && age_q <= 8'h08) else $error("valid cleared wrongly");
    valid_set_a: assert property ($rose(status.out_valid) |-> adr_q == 3'h0 &&
        (dat_q == 8'h01 || dat_q == 8'h02)) else $error("valid set wrongly");
    hash_squeeze_a: assert property ($rose(status.out_valid) && dat_q == 8'h02
        |-> $fell(status.busy)) else $error("hash squeeze mistimed");
    out_change_a: assert property ($changed(byte_output_bus) |-> status.out_valid)
        else $error("output moved without digest");
endmodule
bind shba_core shba_core_asserts chk_i (.ref_clk(ref_clk), .sys_rst(sys_rst),
    .byte_input_bus(byte_input_bus), .ctrl_in(ctrl_in),
    .byte_output_bus(byte_output_bus), .status(status));
`default_nettype wire

// file: dv/shba_host.sv
// Host model driving the strobed byte register port.
// Assumes one pulse task call at a time, from the bench.
`default_nettype none
module shba_host
    import shba_pkg::*;
(
    input  wire logic                    ref_clk,
    output var shba_pkg::shba_ctrl_in_type ctrl,
    output var logic [7:0]               byte_input_bus
);
    timeunit 1ns;
    timeprecision 100ps;
    initial begin
        ctrl = '0;
        byte_input_bus = 8'h00;
    end
    // Address and data settle three clocks ahead of the strobe
    task automatic pulse(input logic wr, input logic [2:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        #2;
        ctrl.addr = a;
        byte_input_bus = d;
        repeat (3) @(posedge ref_clk);
        #2;
        ctrl.wr_strobe = wr;
        ctrl.rd_strobe = !wr;
        repeat (4) @(posedge ref_clk);
        #2;
        ctrl.wr_strobe = 1'b0;
        ctrl.rd_strobe = 1'b0;
        repeat (4) @(posedge ref_clk);
        #2;
        ctrl.addr = ~a;
        byte_input_bus = ~d;
    endtask
endmodule
`default_nettype wire

// file: dv/testbench.sv
// Self-checking bench for the sponge hash core.
// Assumes package, host model and checker compiled first.
`default_nettype none
module testbench;
    timeunit 1ns;
    timeprecision 100ps;
    import shba_pkg::*;
    logic             ref_clk = 1'b0;
    logic             sys_rst = 1'b1;
    logic [7:0]       byte_input_bus, byte_output_bus;
    shba_ctrl_in_type ctrl_in;
    shba_status_type  status;
    logic [87:0]      st;
    logic [31:0]      seed = 32'h0000_80EA;
    int               bad_count = 0;
    int               n_checks = 0;
    logic [3:0] sbox [16] = '{4'hE, 4'hD, 4'hB, 4'h0, 4'h2, 4'h1, 4'h4, 4'hF,
                              4'h7, 4'hA, 4'h8, 4'h5, 4'h9, 4'hC, 4'h3, 4'h6};
    always #12.5 ref_clk = ~ref_clk;
    shba_core dut (.ref_clk(ref_clk), .sys_rst(sys_rst), .byte_input_bus(byte_input_bus),
        .ctrl_in(ctrl_in), .byte_output_bus(byte_output_bus), .status(status));
    shba_host host (.ref_clk(ref_clk), .ctrl(ctrl_in), .byte_input_bus(byte_input_bus));
    function automatic logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    function automatic logic [87:0] perm(input logic [87:0] s);
        logic [87:0] t;
        logic [5:0]  c;
        c = 6'h05;
        for (int r = 0; r < 45; r++) begin
            s[5:0] ^= c;
            for (int k = 0; k < 6; k++) s[87-k] ^= c[k];
            for (int k = 0; k < 22; k++) s[4*k+:4] = sbox[s[4*k+:4]];
            for (int k = 0; k < 87; k++) t[(k*22)%87] = s[k];
            t[87] = s[87];
            s = t;
            c = {c[4:0], c[5] ^ c[4]};
        end
        return s;
    endfunction
    task automatic chk(input string n, input logic [87:0] seen, input logic [87:0] exp);
        n_checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("unexpected %s: expected %h seen %h", n, exp, seen);
        end
    endtask
    task automatic end_of_test();
        if (bad_count == 0 && n_checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    task automatic settle();
        for (int i = 0; i < 60; i++) begin
            @(posedge ref_clk);
            #2;
            if (status.busy === 1'b0) return;
        end
        bad_count++;
        end_of_test();
    endtask
    task automatic absorb(input logic [7:0] b);
        host.pulse(1'b1, 3'h1, b);
        st = perm(st ^ {80'h0, b});
        settle();
    endtask
    task automatic read_all();
        for (int i = 0; i < 11; i++) begin
            chk("digest byte", {80'h0, byte_output_bus}, {80'h0, st[8*i+:8]});
            if (i < 10) host.pulse(1'b0, 3'h2, 8'h00);
        end
    endtask
    initial begin
        repeat (8) @(posedge ref_clk);
        #2;
        sys_rst = 1'b0;
        chk("idle outputs", {78'h0, status, byte_output_bus}, 88'h0);
        host.pulse(1'b1, 3'h0, 8'h00);
        st = 88'h0;
        for (int i = 0; i < 6; i++) absorb(i == 0 ? 8'h00 : i == 5 ? 8'hFF : 8'(xs()));
        // A second write inside the run must be dropped
        host.pulse(1'b1, 3'h1, 8'h5A);
        st = perm(st ^ 88'h5A);
        host.pulse(1'b1, 3'h1, 8'hC3);
        settle();
        host.pulse(1'b1, 3'h0, 8'h03);
        chk("valid", {87'h0, status.out_valid}, 88'h0);
        host.pulse(1'b1, 3'h0, 8'h01);
        chk("valid", {87'h0, status.out_valid}, 88'h1);
        read_all();
        // Clear first so that the hash command raises digest-valid afresh
        host.pulse(1'b1, 3'h0, 8'h00);
        chk("valid", {87'h0, status.out_valid}, 88'h0);
        st = 88'h0;
        absorb(8'(xs()));
        host.pulse(1'b1, 3'h0, 8'h02);
        st = perm(st ^ 88'h81);
        settle();
        chk("valid", {87'h0, status.out_valid}, 88'h1);
        read_all();
        absorb(8'h81);
        host.pulse(1'b1, 3'h0, 8'h01);
        read_all();
        end_of_test();
    end
endmodule
`default_nettype wire
